// ==== inc/apm_pkg.sv ====
package apm_pkg;
   localparam int unsigned PIN_COUNT        = 12;
   localparam int unsigned CHAN_COUNT       = 6;
   localparam int unsigned SEL_SLOTS        = 16;
   localparam int unsigned ADDR_W           = 8;
   localparam int unsigned DATA_W           = 32;

   // register byte offsets
   localparam logic [7:0] OFS_SELECT        = 8'h00;
   localparam logic [7:0] OFS_DATA          = 8'h04;
   localparam logic [7:0] OFS_SET           = 8'h08;
   localparam logic [7:0] OFS_CLEAR         = 8'h0C;
   localparam logic [7:0] OFS_TOGGLE        = 8'h10;
   localparam logic [7:0] OFS_DIR           = 8'h14;
   localparam logic [7:0] OFS_PIN_LEVEL     = 8'h18;
   localparam logic [7:0] OFS_ROUTE_STATUS  = 8'h1C;

   // values after reset
   localparam logic [15:0] RST_SELECT_SLOTS = 16'hFFFF;
   localparam logic [5:0]  RST_DATA         = 6'h00;
   localparam logic [5:0]  RST_DIR          = 6'h00;
   localparam logic [31:0] RST_RDATA        = 32'h0000_0000;

   // odd select bit of a slot is 2*slot+1; pin order A0 A2 A3 A4 A6 A7 B0 B2 B3 B4 B6 B7
   localparam int unsigned PIN_SLOT [PIN_COUNT]   = '{0, 2, 3, 4, 6, 7, 8, 10, 11, 12, 14, 15};
   // which pin each digital channel sits on
   localparam int unsigned CHAN_PIN [CHAN_COUNT]  = '{1, 3, 4, 7, 9, 10};
   // digital channel numbers 18 20 22 26 28 30
   localparam int unsigned CHAN_NUM [CHAN_COUNT]  = '{18, 20, 22, 26, 28, 30};
   // pins that have a digital function
   localparam logic [11:0] PIN_HAS_DIGITAL        = 12'h69A;
endpackage

// ==== rtl/apm_channel.sv ====
`timescale 1ns/10ps
module apm_channel
   import apm_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic analog_mode,
   input  wire logic dir_out,
   input  wire logic latch_val,
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe,
   output logic      level
);
   logic pin_o_q;
   logic pin_oe_q;
   logic level_q;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_oe_q <= 1'b0;
      end
      else
      begin
         pin_oe_q <= ~analog_mode & dir_out;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_o_q <= 1'b0;
      end
      else
      begin
         pin_o_q <= latch_val;
      end
   end

   // input path closed in analog mode, reads zero
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         level_q <= 1'b0;
      end
      else
      begin
         level_q <= ~analog_mode & pin_i;
      end
   end

   assign pin_o  = pin_o_q;
   assign pin_oe = pin_oe_q;
   assign level  = level_q;
endmodule

// ==== rtl/apm_second_analog_pin_mux.sv ====
// Function
// - after reset all twelve pins analog, digital function off
// - only the control processor reaches the registers; other accesses ignored
// - odd select bit 0 puts its pin in digital mode, if the pin has a digital function
// - odd select bit 1 routes its pin to converter or comparator
// - even select bits ignored, read as zero
// - bit 9 picks digital channel twenty or analog for chan-A4 pin
// - pins A0 A3 A7 B0 B3 B7 stay analog, digital reserved
// - A2 A4 A6 to channels 18 20 22; B2 B4 B6 to 26 28 30
// - read/write six channel values, per-bit direction control
// - no pull-up control on these channels
`timescale 1ns/10ps
module apm_second_analog_pin_mux
   import apm_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic                  reg_from_ctrl_cpu,
   output logic      [DATA_W-1:0]     reg_rdata,
   input  wire logic [CHAN_COUNT-1:0] chan_pin_i,
   output logic      [CHAN_COUNT-1:0] chan_pin_o,
   output logic      [CHAN_COUNT-1:0] chan_pin_oe,
   output logic      [PIN_COUNT-1:0]  analog_route_en
);
   logic [SEL_SLOTS-1:0]  sel_slot_q;
   logic [CHAN_COUNT-1:0] data_q;
   logic [CHAN_COUNT-1:0] data_d;
   logic [CHAN_COUNT-1:0] dir_q;
   logic [DATA_W-1:0]     rdata_q;
   logic [DATA_W-1:0]     rdata_d;
   logic [PIN_COUNT-1:0]  pin_analog;
   logic [CHAN_COUNT-1:0] chan_analog;
   logic [CHAN_COUNT-1:0] chan_level;
   logic [CHAN_COUNT-1:0] data_view;
   logic [DATA_W-1:0]     select_view;
   logic                  wr_ok;
   logic                  rd_ok;

   assign wr_ok = reg_wr & reg_from_ctrl_cpu;
   assign rd_ok = reg_rd & reg_from_ctrl_cpu;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sel_slot_q <= RST_SELECT_SLOTS;
      end
      else if (wr_ok && reg_addr == OFS_SELECT)
      begin
         for (int s = 0; s < SEL_SLOTS; s++)
         begin
            sel_slot_q[s] <= reg_wdata[2*s+1];
         end
      end
   end

   always_comb
   begin
      pin_analog = '0;
      for (int p = 0; p < PIN_COUNT; p++)
      begin
         pin_analog[p] = sel_slot_q[PIN_SLOT[p]] | ~PIN_HAS_DIGITAL[p];
      end
   end

   // analog switch closes only while the pin is in analog mode
   assign analog_route_en = pin_analog;

   // chan 1 (twenty) follows slot 4, bit 9
   always_comb
   begin
      chan_analog = '0;
      for (int c = 0; c < CHAN_COUNT; c++)
      begin
         chan_analog[c] = pin_analog[CHAN_PIN[c]];
      end
   end

   // output latch write, set, clear, toggle
   always_comb
   begin
      data_d = data_q;
      if (wr_ok)
      begin
         unique case (reg_addr)
            OFS_DATA:   data_d = reg_wdata[CHAN_COUNT-1:0];
            OFS_SET:    data_d = data_q | reg_wdata[CHAN_COUNT-1:0];
            OFS_CLEAR:  data_d = data_q & ~reg_wdata[CHAN_COUNT-1:0];
            OFS_TOGGLE: data_d = data_q ^ reg_wdata[CHAN_COUNT-1:0];
            default:    data_d = data_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         data_q <= RST_DATA;
      end
      else
      begin
         data_q <= data_d;
      end
   end

   // direction, 1 is output; reset input
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         dir_q <= RST_DIR;
      end
      else if (wr_ok && reg_addr == OFS_DIR)
      begin
         dir_q <= reg_wdata[CHAN_COUNT-1:0];
      end
   end

   for (genvar c = 0; c < CHAN_COUNT; c++)
   begin : g_chan
      apm_channel u_chan
      (
         .clk_sys     (clk_sys),
         .rst         (rst),
         .analog_mode (chan_analog[c]),
         .dir_out     (dir_q[c]),
         .latch_val   (data_q[c]),
         .pin_i       (chan_pin_i[c]),
         .pin_o       (chan_pin_o[c]),
         .pin_oe      (chan_pin_oe[c]),
         .level       (chan_level[c])
      );
   end

   // outputs read back the latch, inputs the sampled pin
   always_comb
   begin
      data_view = '0;
      for (int c = 0; c < CHAN_COUNT; c++)
      begin
         data_view[c] = (dir_q[c] && !chan_analog[c]) ? data_q[c] : chan_level[c];
      end
   end

   always_comb
   begin
      select_view = '0;
      for (int s = 0; s < SEL_SLOTS; s++)
      begin
         select_view[2*s+1] = sel_slot_q[s];
      end
   end

   always_comb
   begin
      rdata_d = '0;
      if (rd_ok)
      begin
         unique case (reg_addr)
            OFS_SELECT:       rdata_d = select_view;
            OFS_DATA:         rdata_d = {{(DATA_W-CHAN_COUNT){1'b0}}, data_view};
            OFS_DIR:          rdata_d = {{(DATA_W-CHAN_COUNT){1'b0}}, dir_q};
            OFS_PIN_LEVEL:    rdata_d = {{(DATA_W-CHAN_COUNT){1'b0}}, chan_level};
            OFS_ROUTE_STATUS: rdata_d = {{(DATA_W-PIN_COUNT){1'b0}}, pin_analog};
            default:          rdata_d = '0;
         endcase
      end
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rdata_q <= RST_RDATA;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
endmodule

// ==== rtl/placeholder_none.sv ====
`timescale 1ns/10ps

// ==== testbench/apm_mux_chk.sv ====
`timescale 1ns/10ps
module apm_mux_chk
   import apm_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic        reg_from_ctrl_cpu,
   input wire logic [31:0] reg_rdata,
   input wire logic [5:0]  chan_pin_oe,
   input wire logic [11:0] analog_route_en
);
   logic [11:0] want;
   logic [5:0]  chan_an;
   always_comb
   begin
      for (int p = 0; p < PIN_COUNT; p++)
         want[p] = PIN_HAS_DIGITAL[p] ? reg_wdata[2*PIN_SLOT[p]+1] : 1'b1;
   end
   assign chan_an = {analog_route_en[10], analog_route_en[9], analog_route_en[7],
                     analog_route_en[4], analog_route_en[3], analog_route_en[1]};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence sel_wr;
      reg_wr && reg_from_ctrl_cpu && reg_addr == OFS_SELECT;
   endsequence
   sequence sel_rd;
      reg_rd && reg_from_ctrl_cpu && reg_addr == OFS_SELECT;
   endsequence
   rst_analog_a: assert property (disable iff (1'b0) rst |=> analog_route_en == 12'hFFF && chan_pin_oe == 6'h00)
      else $error("reset state wrong");
   sel_route_a: assert property (sel_wr |=> analog_route_en == $past(want))
      else $error("routing differs from select");
   chan_twenty_a: assert property (sel_wr ##0 !reg_wdata[9] |=> !analog_route_en[3])
      else $error("bit 9 ignored");
   reserved_pins_a: assert property ((analog_route_en | PIN_HAS_DIGITAL) == 12'hFFF)
      else $error("reserved pin left digital");
   foreign_wr_a: assert property (reg_wr && !reg_from_ctrl_cpu |=> $stable(analog_route_en))
      else $error("foreign write took effect");
   rdata_idle_a: assert property (!(reg_rd && reg_from_ctrl_cpu) |=> reg_rdata == 32'h0)
      else $error("read data without read");
   even_zero_a: assert property (sel_rd |=> (reg_rdata & 32'h5555_5555) == 32'h0)
      else $error("even bits read nonzero");
   drive_digital_a: assert property ((chan_pin_oe & $past(chan_an)) == 6'h00)
      else $error("analog pin driven");
endmodule
bind apm_second_analog_pin_mux apm_mux_chk chk
(
   .clk_sys           (clk_sys),
   .rst               (rst),
   .reg_addr          (reg_addr),
   .reg_wdata         (reg_wdata),
   .reg_wr            (reg_wr),
   .reg_rd            (reg_rd),
   .reg_from_ctrl_cpu (reg_from_ctrl_cpu),
   .reg_rdata         (reg_rdata),
   .chan_pin_oe       (chan_pin_oe),
   .analog_route_en   (analog_route_en)
);

// ==== testbench/apm_board.sv ====
`timescale 1ns/10ps
module apm_board
(
   input  wire logic [5:0] drv_o,
   input  wire logic [5:0] drv_oe,
   input  wire logic [5:0] ext_lvl,
   output logic      [5:0] chan_pin_i
);
   // pin level is the driven value where the output is enabled, the external level otherwise
   assign chan_pin_i = (drv_oe & drv_o) | (~drv_oe & ext_lvl);
endmodule

// ==== testbench/apm_second_analog_pin_mux_test.sv ====
`timescale 1ns/10ps
module apm_second_analog_pin_mux_test
   import apm_pkg::*;
;
   logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_from_ctrl_cpu = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v, v, lf = 32'h1dbb;
   logic [5:0]  chan_pin_i, chan_pin_o, chan_pin_oe, ext_lvl = 6'h00;
   logic [11:0] analog_route_en;
   int          failures = 0, n_compared = 0;
   initial forever #5 clk_sys = ~clk_sys;
   apm_second_analog_pin_mux dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_from_ctrl_cpu,
                                  .reg_rdata, .chan_pin_i, .chan_pin_o, .chan_pin_oe, .analog_route_en);
   apm_board board (.drv_o(chan_pin_o), .drv_oe(chan_pin_oe), .ext_lvl, .chan_pin_i);
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] route(input logic [31:0] d);
      route = 32'h0;
      for (int p = 0; p < PIN_COUNT; p++)
         route[p] = PIN_HAS_DIGITAL[p] ? d[2*PIN_SLOT[p]+1] : 1'b1;
   endfunction
   // k: 0 set, 1 clear, 2 toggle
   function automatic logic [31:0] latch_op(input logic [31:0] q, input logic [31:0] m, input int k);
      latch_op = (k == 0) ? (q | m) : (k == 1) ? (q & ~m) : (q ^ m);
      latch_op = {26'h0, latch_op[5:0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic c);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      reg_from_ctrl_cpu <= c;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_from_ctrl_cpu <= 1'b1;
   endtask
   task automatic rd(input logic [7:0] a, input logic c);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      reg_from_ctrl_cpu <= c;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_from_ctrl_cpu <= 1'b1;
      #1 rd_v = reg_rdata;
   endtask
   task automatic conclude;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #100000;
      failures++;
      conclude;
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(OFS_SELECT, 1'b1);
      chk(rd_v, 32'hAAAA_AAAA);
      chk({20'h0, analog_route_en}, 32'hFFF);
      // corner values first, then random
      for (int i = 0; i < 24; i++)
      begin
         lf = nxt(lf);
         v = (i == 0) ? 32'hFFFF_FDFF : (i == 1) ? 32'h5555_5555 : lf;
         wr(OFS_SELECT, v, 1'b1);
         #1 chk({20'h0, analog_route_en}, route(v));
         rd(OFS_SELECT, 1'b1);
         chk(rd_v, v & 32'hAAAA_AAAA);
         rd(OFS_ROUTE_STATUS, 1'b1);
         chk(rd_v, route(v));
         wr(OFS_SELECT, ~v, 1'b0);
         rd(OFS_SELECT, 1'b0);
         chk({20'h0, analog_route_en}, route(v));
         chk(rd_v, 32'h0);
      end
      wr(OFS_SELECT, 32'h0, 1'b1);
      wr(OFS_DIR, 32'h3F, 1'b1);
      lf = nxt(lf);
      wr(OFS_DATA, lf, 1'b1);
      @(posedge clk_sys);
      #1 chk({26'h0, chan_pin_oe}, 32'h3F);
      chk({26'h0, chan_pin_o}, {26'h0, lf[5:0]});
      rd(OFS_DATA, 1'b1);
      chk(rd_v, {26'h0, lf[5:0]});
      // set, clear, toggle on the latch while driving
      v = {26'h0, lf[5:0]};
      for (int k = 0; k < 3; k++)
      begin
         lf = nxt(lf);
         wr((k == 0) ? OFS_SET : (k == 1) ? OFS_CLEAR : OFS_TOGGLE, lf, 1'b1);
         v = latch_op(v, lf, k);
         rd(OFS_DATA, 1'b1);
         chk(rd_v, v);
         chk({26'h0, chan_pin_o}, v);
      end
      // inputs: pins left to the board
      wr(OFS_DIR, 32'h0, 1'b1);
      lf = nxt(lf);
      ext_lvl <= lf[5:0];
      // enable drops a cycle late, the level lags one more
      repeat (2) @(posedge clk_sys);
      rd(OFS_PIN_LEVEL, 1'b1);
      chk(rd_v, {26'h0, lf[5:0]});
      rd(OFS_DATA, 1'b1);
      chk(rd_v, {26'h0, lf[5:0]});
      wr(OFS_DIR, 32'h3F, 1'b1);
      wr(OFS_SELECT, 32'hFFFF_FFFF, 1'b1);
      @(posedge clk_sys);
      #1 chk({26'h0, chan_pin_oe}, 32'h0);
      rd(OFS_PIN_LEVEL, 1'b1);
      chk(rd_v, 32'h0);
      rd(8'h20, 1'b1);
      chk(rd_v, 32'h0);
      // second reset after a driving digital setup
      wr(OFS_SELECT, 32'h0, 1'b1);
      wr(OFS_DATA, 32'h3F, 1'b1);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      #1 chk({20'h0, analog_route_en}, 32'hFFF);
      chk({26'h0, chan_pin_oe | chan_pin_o}, 32'h0);
      rd(OFS_SELECT, 1'b1);
      chk(rd_v, 32'hAAAA_AAAA);
      rd(OFS_DIR, 1'b1);
      chk(rd_v, 32'h0);
      conclude;
   end
endmodule
